// ### include/clm_pkg.sv
// Package: register map, field layout and bus carriers of the channel monitor
package clm_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] CLM_IDX_IRQ_SUMMARY = 6'h0B;
  localparam logic [5:0] CLM_IDX_TX_SYNTH    = 6'h0C;
  localparam logic [5:0] CLM_IDX_TX_SPARE    = 6'h0D;
  localparam logic [5:0] CLM_IDX_RX_RECOVERY = 6'h0E;
  localparam logic [5:0] CLM_IDX_RX_MODE     = 6'h0F;
  localparam logic [5:0] CLM_IDX_SECT_CTRL   = 6'h10;
  localparam logic [5:0] CLM_IDX_SECT_STATUS = 6'h11;
  localparam logic [5:0] CLM_IDX_B1_COUNT    = 6'h12;

  // ==========================================================================
  // Field positions
  localparam int unsigned CLM_TX_FLAG_BIT      = 5;
  localparam int unsigned CLM_TX_STAT_BIT      = 3;
  localparam int unsigned CLM_TX_EN_BIT        = 1;
  localparam int unsigned CLM_RX_REF_FLAG_BIT  = 6;
  localparam int unsigned CLM_RX_DATA_FLAG_BIT = 5;
  localparam int unsigned CLM_RX_REF_STAT_BIT  = 4;
  localparam int unsigned CLM_RX_DATA_STAT_BIT = 3;
  localparam int unsigned CLM_RX_REF_EN_BIT    = 2;
  localparam int unsigned CLM_RX_DATA_EN_BIT   = 1;
  localparam int unsigned CLM_MODE_WAN_BIT     = 6;
  localparam int unsigned CLM_MODE_TUNE_BIT    = 5;
  localparam int unsigned CLM_SC_BLOCK_BIT     = 7;
  localparam int unsigned CLM_SC_DESCR_BIT     = 6;
  localparam int unsigned CLM_SC_REFRAME_BIT   = 5;
  localparam int unsigned CLM_SC_SHORT_BIT     = 4;
  localparam int unsigned CLM_SC_PAR_EN_BIT    = 3;
  localparam int unsigned CLM_SS_PAR_FLAG_BIT  = 6;
  localparam int unsigned CLM_SS_FLAG_LSB      = 3;

  // Writable bit masks and reset values
  localparam logic [7:0] CLM_TX_WR_MASK    = 8'hC3;
  localparam logic [7:0] CLM_SPARE_WR_MASK = 8'h0F;
  localparam logic [7:0] CLM_RX_WR_MASK    = 8'h87;
  localparam logic [7:0] CLM_MODE_WR_MASK  = 8'hFF;
  localparam logic [7:0] CLM_SC_WR_MASK    = 8'hDF;
  localparam logic [7:0] CLM_RESET_BYTE    = 8'h00;

  // Framing pattern bits examined by each framing algorithm
  localparam int unsigned CLM_FRAME_BITS_SHORT = 12;
  localparam int unsigned CLM_FRAME_BITS_FULL  = 48;

  // Bus answers
  localparam logic [1:0] CLM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CLM_RESP_DECERR = 2'h3;

  // ==========================================================================
  // Bus carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } clm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } clm_axi_rsp_t;

endpackage : clm_pkg

// ### rtl/clm_monitor.sv
// Channel lock monitor and receive section control register bank
`timescale 1ns/1ns
module clm_monitor
  import clm_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Register bus
  input  wire clm_pkg::clm_axi_req_t axi_req,
  output      clm_pkg::clm_axi_rsp_t axi_rsp,
  // Sub-block interrupt requests
  input  wire logic                  path_trace_irq_summary,
  input  wire logic                  sync_msg_irq_summary,
  input  wire logic                  wan_sync_irq_summary,
  input  wire logic                  rx_fifo_irq_summary,
  input  wire logic                  tx_fifo_irq_summary,
  // Loop detectors (asynchronous)
  input  wire logic                  tx_synth_freq_off,
  input  wire logic                  rx_recov_freq_off,
  input  wire logic                  rx_line_idle_80,
  input  wire logic                  rx_ref_unlocked,
  // Section framer
  input  wire logic                  sect_out_of_frame,
  input  wire logic                  sect_frame_loss,
  input  wire logic                  sect_signal_loss,
  input  wire logic                  sect_frame_boundary,
  input  wire logic                  sect_b1_valid,
  input  wire logic [3:0]            sect_b1_err_bits,
  // Control outputs
  output      logic                  recovery_wide_area_select,
  output      logic                  recovery_loop_tuning,
  output      logic                  short_framing_select,
  output      logic                  descrambler_disable,
  output      logic                  block_error_count_mode,
  output      logic                  force_reframe,
  output      logic                  irq
);
  import clm_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    clm_axi_rsp_t rsp;
    logic         aw_got;
    logic [5:0]   aw_idx;
    logic         w_got;
    logic [7:0]   w_byte;
    logic         w_lane0;
    logic [3:0]   sync1;
    logic [3:0]   sync2;
    logic         tx_status;
    logic         rx_data_status;
    logic         rx_ref_status;
    logic         tx_flag;
    logic         rx_data_flag;
    logic         rx_ref_flag;
    logic [7:0]   tx_ctrl;
    logic [7:0]   tx_spare;
    logic [7:0]   rx_ctrl;
    logic [7:0]   mode;
    logic [7:0]   sect_ctrl;
    logic [2:0]   alarm_lvl;
    logic [2:0]   alarm_flag;
    logic         par_flag;
    logic [4:0]   summary;
    logic         reframe_pend;
    logic         force_reframe;
    logic [15:0]  b1_count;
    logic         irq;
  } clm_state_t;

  clm_state_t st_r;
  clm_state_t st_nxt;

  logic       do_write;
  logic       rd_fire;
  logic [5:0] rd_idx;
  logic       tx_chg;
  logic       rxd_chg;
  logic       rxr_chg;
  logic [2:0] alarm_chg;
  logic       par_err;
  logic [4:0] b1_add;
  logic [16:0] b1_sum;
  logic [15:0] b1_base;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       wr_hit;

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt   = st_r;
    do_write = st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid;
    rd_fire  = axi_req.arvalid && st_r.rsp.arready;
    rd_idx   = axi_req.araddr[7:2];
    rd_byte  = CLM_RESET_BYTE;
    rd_hit   = 1'b1;
    wr_hit   = 1'b1;

    // Write address and data are taken independently
    if (axi_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_idx = axi_req.awaddr[7:2];
    end
    if (axi_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_byte  = axi_req.wdata[7:0];
      st_nxt.w_lane0 = axi_req.wstrb[0];
    end
    if (st_r.rsp.bvalid && axi_req.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end

    // Level inputs from the analog loops cross through two flops
    st_nxt.sync1 = {rx_ref_unlocked, rx_line_idle_80, rx_recov_freq_off,
                    tx_synth_freq_off};
    st_nxt.sync2 = st_r.sync1;
    tx_chg  = st_r.sync2[0] ^ st_r.tx_status;
    rxd_chg = (st_r.sync2[1] | st_r.sync2[2]) ^ st_r.rx_data_status;
    rxr_chg = st_r.sync2[3] ^ st_r.rx_ref_status;
    st_nxt.tx_status      = st_r.sync2[0];
    st_nxt.rx_data_status = st_r.sync2[1] | st_r.sync2[2];
    st_nxt.rx_ref_status  = st_r.sync2[3];

    // Section alarms and parity errors come from the same clock
    st_nxt.alarm_lvl = {sect_signal_loss, sect_frame_loss, sect_out_of_frame};
    alarm_chg = st_nxt.alarm_lvl ^ st_r.alarm_lvl;
    par_err   = sect_b1_valid && (sect_b1_err_bits != 4'h0);
    st_nxt.summary = {tx_fifo_irq_summary, rx_fifo_irq_summary,
                      wan_sync_irq_summary, sync_msg_irq_summary,
                      path_trace_irq_summary};

    // Read: answer data and read-clear side effects
    if (st_r.rsp.rvalid && axi_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    case (rd_idx)
      CLM_IDX_IRQ_SUMMARY: rd_byte = {3'h0, st_r.summary};
      CLM_IDX_TX_SYNTH: begin
        rd_byte = st_r.tx_ctrl;
        rd_byte[CLM_TX_FLAG_BIT] = st_r.tx_flag;
        rd_byte[CLM_TX_STAT_BIT] = st_r.tx_status;
      end
      CLM_IDX_TX_SPARE: rd_byte = st_r.tx_spare;
      CLM_IDX_RX_RECOVERY: begin
        rd_byte = st_r.rx_ctrl;
        rd_byte[CLM_RX_REF_FLAG_BIT]  = st_r.rx_ref_flag;
        rd_byte[CLM_RX_DATA_FLAG_BIT] = st_r.rx_data_flag;
        rd_byte[CLM_RX_REF_STAT_BIT]  = st_r.rx_ref_status;
        rd_byte[CLM_RX_DATA_STAT_BIT] = st_r.rx_data_status;
      end
      CLM_IDX_RX_MODE:     rd_byte = st_r.mode;
      CLM_IDX_SECT_CTRL:   rd_byte = st_r.sect_ctrl;
      CLM_IDX_SECT_STATUS: rd_byte = {1'b0, st_r.par_flag,
                                      st_r.alarm_flag, st_r.alarm_lvl};
      CLM_IDX_B1_COUNT:    rd_byte = st_r.b1_count[7:0];
      default:             rd_hit  = 1'b0;
    endcase
    if (rd_fire) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp  = rd_hit ? CLM_RESP_OKAY : CLM_RESP_DECERR;
      st_nxt.rsp.rdata  = {24'h0, rd_byte};
      if (rd_idx == CLM_IDX_B1_COUNT) begin
        st_nxt.rsp.rdata = {16'h0, st_r.b1_count};
      end
    end

    // Sticky flags: a change in the clearing cycle still sets the flag
    st_nxt.tx_flag = (st_r.tx_flag &
                      !(rd_fire && rd_idx == CLM_IDX_TX_SYNTH)) |
                     tx_chg;
    st_nxt.rx_data_flag = (st_r.rx_data_flag &
                           !(rd_fire && rd_idx == CLM_IDX_RX_RECOVERY)) |
                          rxd_chg;
    st_nxt.rx_ref_flag = (st_r.rx_ref_flag &
                          !(rd_fire && rd_idx == CLM_IDX_RX_RECOVERY)) |
                         rxr_chg;
    st_nxt.alarm_flag = (st_r.alarm_flag &
                         {3{!(rd_fire && rd_idx == CLM_IDX_SECT_STATUS)}}) |
                        alarm_chg;
    st_nxt.par_flag = (st_r.par_flag &
                       !(rd_fire && rd_idx == CLM_IDX_SECT_STATUS)) |
                      par_err;

    // Error counter; reading it restarts accumulation without losing events
    b1_base = (rd_fire && rd_idx == CLM_IDX_B1_COUNT) ? 16'h0000
                                                       : st_r.b1_count;
    b1_add = 5'h00;
    if (sect_b1_valid) begin
      b1_add = st_r.sect_ctrl[CLM_SC_BLOCK_BIT] ?
               {4'h0, par_err} : {1'b0, sect_b1_err_bits};
    end
    b1_sum = {1'b0, b1_base} + {12'h000, b1_add};
    st_nxt.b1_count = b1_sum[16] ? 16'hFFFF : b1_sum[15:0];

    // Register write; only byte lane 0 carries register data
    if (do_write) begin
      st_nxt.aw_got     = 1'b0;
      st_nxt.w_got      = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      case (st_r.aw_idx)
        CLM_IDX_TX_SYNTH: if (st_r.w_lane0) begin
          st_nxt.tx_ctrl = st_r.w_byte & CLM_TX_WR_MASK;
        end
        CLM_IDX_TX_SPARE: if (st_r.w_lane0) begin
          st_nxt.tx_spare = st_r.w_byte & CLM_SPARE_WR_MASK;
        end
        CLM_IDX_RX_RECOVERY: if (st_r.w_lane0) begin
          st_nxt.rx_ctrl = st_r.w_byte & CLM_RX_WR_MASK;
        end
        CLM_IDX_RX_MODE: if (st_r.w_lane0) begin
          st_nxt.mode = st_r.w_byte & CLM_MODE_WR_MASK;
        end
        CLM_IDX_SECT_CTRL: if (st_r.w_lane0) begin
          st_nxt.sect_ctrl = st_r.w_byte & CLM_SC_WR_MASK;
        end
        CLM_IDX_IRQ_SUMMARY, CLM_IDX_SECT_STATUS, CLM_IDX_B1_COUNT: begin
          wr_hit = 1'b1;
        end
        default: wr_hit = 1'b0;
      endcase
      st_nxt.rsp.bresp = wr_hit ? CLM_RESP_OKAY : CLM_RESP_DECERR;
    end

    // Forced reframe waits for the framer's next boundary
    st_nxt.force_reframe = st_r.reframe_pend && sect_frame_boundary;
    st_nxt.reframe_pend = (st_r.reframe_pend && !sect_frame_boundary) ||
                          (do_write && st_r.w_lane0 &&
                           st_r.aw_idx == CLM_IDX_SECT_CTRL &&
                           st_r.w_byte[CLM_SC_REFRAME_BIT]);

    // One interrupt line gathers every enabled flag
    st_nxt.irq = (st_nxt.tx_flag &&
                  st_r.tx_ctrl[CLM_TX_EN_BIT]) ||
                 (st_nxt.rx_data_flag &&
                  st_r.rx_ctrl[CLM_RX_DATA_EN_BIT]) ||
                 (st_nxt.rx_ref_flag && st_r.rx_ctrl[CLM_RX_REF_EN_BIT]) ||
                 (|(st_nxt.alarm_flag & st_r.sect_ctrl[2:0])) ||
                 (st_nxt.par_flag &&
                  st_r.sect_ctrl[CLM_SC_PAR_EN_BIT]);

    // Each channel is ready only while it holds nothing unanswered, so one write and one read at a time
    st_nxt.rsp.awready = !st_nxt.aw_got && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready  = !st_nxt.w_got && !st_nxt.rsp.bvalid;
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign axi_rsp                   = st_r.rsp;
  assign recovery_wide_area_select = st_r.mode[CLM_MODE_WAN_BIT];
  assign recovery_loop_tuning      = st_r.mode[CLM_MODE_TUNE_BIT];
  assign short_framing_select      =
           st_r.sect_ctrl[CLM_SC_SHORT_BIT];
  assign descrambler_disable       =
           st_r.sect_ctrl[CLM_SC_DESCR_BIT];
  assign block_error_count_mode    =
           st_r.sect_ctrl[CLM_SC_BLOCK_BIT];
  assign force_reframe             = st_r.force_reframe;
  assign irq                       = st_r.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence tx_input_steady_s;
    tx_synth_freq_off [*4];
  endsequence

  sequence reframe_write_s;
    do_write && st_r.w_lane0 && st_r.aw_idx == CLM_IDX_SECT_CTRL &&
    st_r.w_byte[CLM_SC_REFRAME_BIT];
  endsequence

  // Boundary lands while a reframe is pending; frames never abut
  sequence reframe_fire_s;
    st_r.reframe_pend && sect_frame_boundary;
  endsequence

  tx_status_follow_a:
    assert property (tx_input_steady_s |-> st_r.tx_status)
    else $error("tx lock status missed a steady input");
  rx_data_follow_a:
    assert property (rx_line_idle_80 [*4] |-> st_r.rx_data_status)
    else $error("rx data status missed idle line");
  rx_ref_follow_a:
    assert property (!rx_ref_unlocked [*4] |-> !st_r.rx_ref_status)
    else $error("rx reference status not cleared when locked");
  tx_flag_set_a:
    assert property (st_r.tx_status != $past(st_r.tx_status) |->
                     st_r.tx_flag)
    else $error("tx flag not set on status change");
  rx_flag_clear_a:
    assert property (rd_fire && rd_idx == CLM_IDX_RX_RECOVERY && !rxd_chg
                     |=> !st_r.rx_data_flag)
    else $error("rx data flag not cleared by read");
  alarm_flag_set_a:
    assert property ($changed(sect_out_of_frame) |=>
                     st_r.alarm_flag[0] ##1 st_r.alarm_flag[0] ||
                     $past(rd_fire))
    else $error("frame alarm change lost");
  irq_enabled_a:
    assert property (st_r.tx_flag && st_r.tx_ctrl[CLM_TX_EN_BIT] &&
                     !rd_fire |=> st_r.irq)
    else $error("interrupt low with enabled flag set");
  reframe_arm_a:
    assert property (reframe_write_s |=> st_r.reframe_pend)
    else $error("forced reframe write not held pending");
  reframe_pulse_a:
    assert property (reframe_fire_s |=> force_reframe ##1 !force_reframe)
    else $error("forced reframe not issued at boundary");
  block_count_a:
    assert property (block_error_count_mode && par_err && !rd_fire &&
                     st_r.b1_count < 16'hFFFF |=>
                     st_r.b1_count == $past(st_r.b1_count) + 16'h0001)
    else $error("block count did not add one");
  write_answer_a:
    assert property (do_write |=> st_r.rsp.bvalid ##0 !st_r.rsp.awready)
    else $error("write not answered next cycle");

endmodule : clm_monitor

// ### testbench/clm_line_model.sv
// Line-side model: loop detectors and section framer feeding the monitor
`timescale 1ns/1ns
module clm_line_model #(
  parameter int FRAME_CYC = 16
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench commands
  input  wire logic [3:0] det_cmd,
  input  wire logic [2:0] alarm_cmd,
  input  wire logic [3:0] b1_cmd,
  // Loop detectors
  output      logic       tx_synth_freq_off,
  output      logic       rx_recov_freq_off,
  output      logic       rx_line_idle_80,
  output      logic       rx_ref_unlocked,
  // Section framer
  output      logic       sect_out_of_frame,
  output      logic       sect_frame_loss,
  output      logic       sect_signal_loss,
  output      logic       sect_frame_boundary,
  output      logic       sect_b1_valid,
  output      logic [3:0] sect_b1_err_bits
);
  // ==========================================================================
  // State
  int         cyc_r;
  int         lock_r;
  logic [3:0] b1_pend_r;
  logic       last_w;

  assign last_w = (cyc_r == FRAME_CYC - 1);

  initial begin
    tx_synth_freq_off = 1'b0;
    rx_recov_freq_off = 1'b0;
    rx_line_idle_80   = 1'b0;
    rx_ref_unlocked   = 1'b1;
  end

  // ==========================================================================
  // Detectors move on the falling edge, so they stay unrelated to sampling
  always @(negedge aclk) begin
    tx_synth_freq_off = det_cmd[0];
    rx_recov_freq_off = det_cmd[1];
    rx_line_idle_80   = det_cmd[2];
    rx_ref_unlocked   = det_cmd[3] | (lock_r < 20);
  end

  // ==========================================================================
  // Framer: boundary every FRAME_CYC cycles, parity report on the boundary
  always @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r               <= 0;
      lock_r              <= 0;
      b1_pend_r           <= 4'h0;
      sect_frame_boundary <= 1'b0;
      sect_b1_valid       <= 1'b0;
      sect_b1_err_bits    <= 4'hF;
      {sect_signal_loss, sect_frame_loss, sect_out_of_frame} <= 3'h0;
    end else begin
      lock_r              <= (lock_r < 20) ? lock_r + 1 : lock_r;
      cyc_r               <= last_w ? 0 : cyc_r + 1;
      sect_frame_boundary <= last_w;
      sect_b1_valid       <= last_w && (b1_pend_r != 4'h0);
      // Off the boundary cycle the bits toggle so stale data is never reused
      sect_b1_err_bits    <= last_w ? b1_pend_r : ~sect_b1_err_bits;
      {sect_signal_loss, sect_frame_loss, sect_out_of_frame} <= alarm_cmd;
      if (b1_cmd != 4'h0) begin
        b1_pend_r <= b1_cmd;
      end else if (last_w) begin
        b1_pend_r <= 4'h0;
      end
    end
  end
endmodule : clm_line_model

// ### testbench/tb.sv
// Testbench: register bus, lock monitor and section control checks
`timescale 1ns/1ns
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, x); end end
module tb;
  import clm_pkg::*;
  // ==========================================================================
  // Signals
  logic         aclk, aresetn;
  clm_axi_req_t req;
  clm_axi_rsp_t rsp;
  logic [4:0]   summ;
  logic [3:0]   det_cmd, b1_cmd;
  logic [2:0]   alarm_cmd;
  logic         wide, tune, shrt, descr, blk, refr, irq;
  logic         tx_off, rx_off, rx_idle, ref_unl, oof, lof, los, fb, b1v;
  logic [3:0]   b1e;
  logic [7:0]   lfsr_r;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           error_cnt, n_compared, cnt, e;
  logic [7:0]   la[4] = '{8'h30, 8'h38, 8'h38, 8'h38};
  logic [7:0]   ev;
  // Bench model: written register values and injected parity error counts
  int           shadow[int];
  int           b1_q[$];
  int           le[4] = '{1, 1, 1, 2};
  int           ls[4] = '{3, 3, 3, 4};
  int           lf[4] = '{5, 5, 5, 6};
  logic [7:0]   rst_a[4] = '{8'h30, 8'h34, 8'h3C, 8'h40};

  // ==========================================================================
  // Instances
  clm_monitor DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .path_trace_irq_summary(summ[0]),
    .sync_msg_irq_summary(summ[1]), .wan_sync_irq_summary(summ[2]),
    .rx_fifo_irq_summary(summ[3]), .tx_fifo_irq_summary(summ[4]),
    .tx_synth_freq_off(tx_off), .rx_recov_freq_off(rx_off),
    .rx_line_idle_80(rx_idle), .rx_ref_unlocked(ref_unl),
    .sect_out_of_frame(oof), .sect_frame_loss(lof), .sect_signal_loss(los),
    .sect_frame_boundary(fb), .sect_b1_valid(b1v), .sect_b1_err_bits(b1e),
    .recovery_wide_area_select(wide), .recovery_loop_tuning(tune),
    .short_framing_select(shrt), .descrambler_disable(descr),
    .block_error_count_mode(blk), .force_reframe(refr), .irq(irq));
  clm_line_model #(.FRAME_CYC(16)) u_line (.aclk(aclk), .aresetn(aresetn),
    .det_cmd(det_cmd), .alarm_cmd(alarm_cmd), .b1_cmd(b1_cmd),
    .tx_synth_freq_off(tx_off), .rx_recov_freq_off(rx_off),
    .rx_line_idle_80(rx_idle), .rx_ref_unlocked(ref_unl),
    .sect_out_of_frame(oof), .sect_frame_loss(lof), .sect_signal_loss(los),
    .sect_frame_boundary(fb), .sect_b1_valid(b1v), .sect_b1_err_bits(b1e));

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    req.awaddr  <= a;
    req.wdata   <= {24'h000000, d};
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    aw = 1'b0;
    w  = 1'b0;
    do begin
      @(posedge aclk);
      aw = aw | rsp.awready;
      w  = w | rsp.wready;
      req.awvalid <= !aw;
      req.wvalid  <= !w;
    end while (!(aw && w));
    while (!rsp.bvalid) @(posedge aclk);
    req.bready <= 1'b0;
    rs = rsp.bresp;
    // Force-reframe is write-only and reads back as zero
    shadow[a] = d & ((a == 8'h40) ? 8'hDF : 8'hFF);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (!rsp.rvalid);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    rs = rsp.rresp;
  endtask : axr

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    req       = '0;
    req.wstrb = 4'hF;
    summ      = 5'h00;
    det_cmd   = 4'h0;
    b1_cmd    = 4'h0;
    alarm_cmd = 3'h0;
    lfsr_r    = 8'h61;
    aresetn   = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rst_a[i]) begin
      axr(rst_a[i]);
      `CHK(rd, 32'h00000000)
    end
    // Recovery loop is unusable until the reference status drops
    do axr(8'h38); while (rd[4] !== 1'b0);
    axr(8'h38);
    // Lock detectors, both directions; enable only on the rising pass
    for (int k = 0; k < 4; k++) begin
      for (int d = 1; d >= 0; d--) begin
        axw(la[k], 8'(d << le[k]));
        det_cmd[k] <= d[0];
        repeat (8) @(posedge aclk);
        `CHK(irq, d[0])
        ev = 8'((d << le[k]) | (d << ls[k]));
        axr(la[k]);
        `CHK(rd[7:0], ev | 8'(1 << lf[k]))
        `CHK(rd[ls[k]], d[0])
        axr(la[k]);
        `CHK(rd[7:0], ev)
        `CHK(irq, 1'b0)
      end
    end
    // Section alarms
    axw(8'h40, 8'h07);
    for (int j = 0; j < 3; j++) begin
      for (int d = 1; d >= 0; d--) begin
        alarm_cmd[j] <= d[0];
        repeat (4) @(posedge aclk);
        `CHK(irq, 1'b1)
        axr(8'h44);
        `CHK(rd[7:0], 8'((1 << (3 + j)) | (d << j)))
      end
    end
    // Parity errors in both counting modes
    for (int m = 0; m < 2; m++) begin
      lfsr_r = lfsr_next(lfsr_r);
      e = 1 + lfsr_r[2:0];
      axw(8'h40, 8'((m << 7) | 8'h08));
      b1_cmd <= e[3:0];
      b1_q.push_back(e);
      @(posedge aclk);
      b1_cmd <= 4'h0;
      repeat (40) @(posedge aclk);
      `CHK(irq, 1'b1)
      axr(8'h44);
      `CHK(rd[6], 1'b1)
      axr(8'h48);
      `CHK(rd[15:0], 16'(m ? b1_q.size() : b1_q.sum()))
      b1_q.delete();
    end
    // Forced reframe yields exactly one pulse
    cnt = 0;
    fork
      axw(8'h40, 8'h20);
      repeat (48) begin
        @(posedge aclk);
        if (refr === 1'b1) cnt++;
      end
    join
    `CHK(cnt, 1)
    axr(8'h40);
    `CHK(rd[7:0], 8'h00)
    // Control bits with random values, reserved bits kept zero
    for (int i = 0; i < 4; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      axw(8'h3C, lfsr_r & 8'h60);
      axr(8'h3C);
      `CHK(rd[7:0], 8'(shadow[8'h3C]))
      `CHK({wide, tune}, lfsr_r[6:5])
      axw(8'h40, lfsr_r & 8'hD0);
      axr(8'h40);
      `CHK(rd[7:0], 8'(shadow[8'h40]))
      `CHK(shrt, lfsr_r[4])
      `CHK({blk, descr}, lfsr_r[7:6])
    end
    // Summary bits follow the sub-block requests
    for (int i = 0; i < 3; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      summ <= lfsr_r[4:0];
      axr(8'h2C);
      `CHK(rd[4:0], lfsr_r[4:0])
    end
    axr(8'h00);
    `CHK(rs, CLM_RESP_DECERR)
    `CHK(rd, 32'h00000000)
    stop_test();
  end
endmodule : tb
